//--- alu_shift_branch_subset.v
// add, arithmetic shift and conditional branch datapath slice
//
// Functional notes
// - signed shifted add into accumulator, one cycle
// - add with carry in, five flags, one cycle
// - single shift right keeps sign, four flags
// - register amount shift updates only N, Z
// - literal amount shift updates only N, Z
// - branch one cycle, taken two, no flags
// - signed and unsigned compare conditions from flags
// - branch conditions on each accumulator overflow
// - branch conditions on each accumulator saturation
`timescale 1ns/100ps
`default_nettype none
`include "alu_shift_branch_subset_consts.vh"

module alu_shift_branch_subset #(
  parameter ACC_W = 40                      // accumulator width
) (
  input  wire        clk_sys,                // core clock
  input  wire        rst,                    // sync reset, active high
  input  wire        op_valid,               // instruction present
  input  wire [2:0]  op_code,                // operation select
  input  wire [4:0]  cond_code,              // branch condition
  input  wire        acc_sel,                // 0 = acc a, 1 = acc b
  input  wire [15:0] operand_a,              // first operand
  input  wire [15:0] operand_b,              // second operand / amount
  input  wire [4:0]  five_bit_literal,       // literal shift amount
  input  wire [3:0]  shift_lit4,             // signed acc add shift
  input  wire [2:0]  reg_addr,               // register address
  input  wire [15:0] reg_wr_data,            // register write data
  input  wire        reg_wr_en,              // write strobe
  input  wire        reg_rd_en,              // read strobe
  output wire [15:0] reg_rd_data,            // read data, cycle after
  output wire [15:0] result,                 // word result
  output wire        result_we,              // word result valid pulse
  output wire        branch_taken,           // taken pulse
  output wire        flush,                  // flush of fetched word
  output wire        carry_flag,             // carry out
  output wire        digit_carry_flag,       // carry out of bit 3
  output wire        negative_flag,          // negative
  output wire        overflow_flag,          // signed overflow
  output wire        zero_flag,              // zero
  output wire        acc_a_overflow_flag,    // acc a guard overflow
  output wire        acc_b_overflow_flag,    // acc b guard overflow
  output wire        acc_a_saturated_flag,   // acc a saturated, sticky
  output wire        acc_b_saturated_flag    // acc b saturated, sticky
);

  // ========================================================
  // state
  reg [ACC_W-1:0] acc_a_reg;                 // accumulator a
  reg [ACC_W-1:0] acc_b_reg;                 // accumulator b
  reg [1:0]       ctrl_reg;                  // saturation enables
  reg [15:0]      rd_data_reg;               // read data
  reg [15:0]      result_reg;                // word result
  reg             result_we_reg;             // result strobe
  reg             taken_reg;                 // branch taken pulse
  reg             flush_reg;                 // flush slot marker
  reg             c_reg;                     // carry
  reg             hc_reg;                    // digit carry
  reg             n_reg;                     // negative
  reg             v_reg;                     // signed overflow
  reg             z_reg;                     // zero
  reg             ovfa_reg;                  // acc a overflow
  reg             ovfb_reg;                  // acc b overflow
  reg             sata_reg;                  // acc a saturated
  reg             satb_reg;                  // acc b saturated

  // ========================================================
  // branch condition evaluation
  function cond_true;
    input [4:0] cc;
    input       c;
    input       n;
    input       v;
    input       z;
    input       ovfa;
    input       ovfb;
    input       sata;
    input       satb;
    begin
      case (cc)
        `COND_C:      cond_true = c;
        `COND_GE:     cond_true = (n == v);
        `COND_GEU:    cond_true = c;
        `COND_GT:     cond_true = ~z & (n == v);
        `COND_GTU:    cond_true = c & ~z;
        `COND_LE:     cond_true = z | (n != v);
        `COND_LEU:    cond_true = ~c | z;
        `COND_LT:     cond_true = (n != v);
        `COND_LTU:    cond_true = ~c;
        `COND_N:      cond_true = n;
        `COND_NC:     cond_true = ~c;
        `COND_NN:     cond_true = ~n;
        `COND_NOV:    cond_true = ~v;
        `COND_NZ:     cond_true = ~z;
        `COND_OVFA:   cond_true = ovfa;
        `COND_OVFB:   cond_true = ovfb;
        `COND_OVF:    cond_true = v;
        `COND_SATA:   cond_true = sata;
        `COND_SATB:   cond_true = satb;
        `COND_ALWAYS: cond_true = 1'b1;
        `COND_Z:      cond_true = z;
        default:      cond_true = 1'b0;                  // unknown code
      endcase
    end
  endfunction

  // ========================================================
  // issue: the word behind a taken branch is dropped
  wire issue = op_valid & ~flush_reg;

  // ========================================================
  // accumulator add datapath
  wire [ACC_W-1:0] acc_cur = acc_sel ? acc_b_reg : acc_a_reg;
  // operand placed in bits 31:16, sign extended above
  wire signed [ACC_W-1:0] acc_base =
    {{(ACC_W-32){operand_a[15]}}, operand_a, 16'h0000};
  wire [3:0] lit4_neg = 4'h0 - shift_lit4;                // left amount
  // positive literal shifts right, negative shifts left
  wire signed [ACC_W-1:0] acc_add =
    shift_lit4[3] ? (acc_base <<< lit4_neg)
                  : (acc_base >>> shift_lit4);
  wire [ACC_W:0] acc_sum =
    {acc_cur[ACC_W-1], acc_cur} + {acc_add[ACC_W-1], acc_add};
  wire acc_wrap = acc_sum[ACC_W] != acc_sum[ACC_W-1];     // beyond width
  wire sat_en   = acc_sel ? ctrl_reg[`CTRL_SAT_B]
                          : ctrl_reg[`CTRL_SAT_A];
  wire do_sat   = acc_wrap & sat_en;
  wire [ACC_W-1:0] acc_max = {1'b0, {(ACC_W-1){1'b1}}};
  wire [ACC_W-1:0] acc_min = {1'b1, {(ACC_W-1){1'b0}}};
  wire [ACC_W-1:0] acc_new =
    do_sat ? (acc_sum[ACC_W] ? acc_min : acc_max)
           : acc_sum[ACC_W-1:0];
  // overflow into guard bits: top bits not all sign
  wire [ACC_W-32:0] acc_top = acc_new[ACC_W-1:31];
  wire acc_ovf = ~((&acc_top) | ~(|acc_top));

  // ========================================================
  // word add with carry datapath
  wire [16:0] cadd_sum =
    {1'b0, operand_a} + {1'b0, operand_b} + {16'h0000, c_reg};
  wire [4:0] cadd_nib =
    {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, c_reg};
  wire cadd_ovf = (operand_a[15] == operand_b[15]) &
                  (cadd_sum[15] != operand_a[15]);

  // ========================================================
  // shift datapath; amounts of 16 or more give all sign bits
  wire [15:0] shr_one = {operand_a[15], operand_a[15:1]};
  wire [15:0] shr_amt = $signed(operand_a) >>> operand_b[4:0];
  wire [15:0] shr_lit = $signed(operand_a) >>> five_bit_literal;

  // ========================================================
  // status register image used for read; writes take reg_wr_data bits directly
  wire [15:0] status_img = {ovfa_reg, ovfb_reg, sata_reg, satb_reg, 3'h0,
                            hc_reg, 4'h0, n_reg, v_reg, z_reg, c_reg};
  wire st_wr = reg_wr_en & (reg_addr == `REG_STATUS);

  // ========================================================
  // flags: software write first, then the issued operation
  always @(posedge clk_sys) begin
    if (rst) begin
      {ovfa_reg, sata_reg, ovfb_reg, satb_reg, hc_reg} <= 5'h00;
      {n_reg, v_reg, z_reg, c_reg} <= 4'h0;
    end else begin
      // software write lands unless an op updates the bit
      if (st_wr) begin
        c_reg    <= reg_wr_data[`ST_C];
        z_reg    <= reg_wr_data[`ST_Z];
        v_reg    <= reg_wr_data[`ST_OVF];
        n_reg    <= reg_wr_data[`ST_N];
        hc_reg   <= reg_wr_data[`ST_DIGIT];
        ovfa_reg <= reg_wr_data[`ST_OVFA];
        ovfb_reg <= reg_wr_data[`ST_OVFB];
        sata_reg <= reg_wr_data[`ST_SATA];
        satb_reg <= reg_wr_data[`ST_SATB];
      end
      if (issue) begin
        case (op_code)
          // accumulator flags of the target only
          `OP_ADD_ACC: begin
            if (acc_sel) begin
              ovfb_reg <= acc_ovf;
              if (do_sat)
                satb_reg <= 1'b1;
            end else begin
              ovfa_reg <= acc_ovf;
              if (do_sat)
                sata_reg <= 1'b1;
            end
          end
          `OP_ADD_CARRY: begin
            c_reg  <= cadd_sum[16];
            hc_reg <= cadd_nib[4];
            n_reg  <= cadd_sum[15];
            v_reg  <= cadd_ovf;
            z_reg  <= (cadd_sum[15:0] == 16'h0000);
          end
          `OP_SHR_ONE: begin
            c_reg  <= operand_a[0];
            n_reg  <= shr_one[15];
            v_reg  <= 1'b0;
            z_reg  <= (shr_one == 16'h0000);
          end
          `OP_SHR_BY_REG: begin
            n_reg <= shr_amt[15];
            z_reg <= (shr_amt == 16'h0000);
          end
          `OP_SHR_BY_LIT: begin
            n_reg <= shr_lit[15];
            z_reg <= (shr_lit == 16'h0000);
          end
          default: begin
            // branches leave every flag alone
          end
        endcase
      end
    end
  end

  // ========================================================
  // accumulators
  always @(posedge clk_sys) begin
    if (rst) begin
      acc_a_reg <= {ACC_W{1'b0}};
      acc_b_reg <= {ACC_W{1'b0}};
    end else if (issue && op_code == `OP_ADD_ACC) begin
      if (acc_sel)
        acc_b_reg <= acc_new;
      else
        acc_a_reg <= acc_new;
    end
  end

  // ========================================================
  // word result to the register file
  always @(posedge clk_sys) begin
    if (rst) begin
      result_reg    <= 16'h0000;
      result_we_reg <= 1'b0;
    end else begin
      result_we_reg <= 1'b0;
      if (issue) begin
        case (op_code)
          `OP_ADD_CARRY: begin
            result_reg    <= cadd_sum[15:0];
            result_we_reg <= 1'b1;
          end
          `OP_SHR_ONE: begin
            result_reg    <= shr_one;
            result_we_reg <= 1'b1;
          end
          `OP_SHR_BY_REG: begin
            result_reg    <= shr_amt;
            result_we_reg <= 1'b1;
          end
          `OP_SHR_BY_LIT: begin
            result_reg    <= shr_lit;
            result_we_reg <= 1'b1;
          end
          default: begin
            // no word result
          end
        endcase
      end
    end
  end

  // ========================================================
  // branch resolve; taken adds one flush slot
  always @(posedge clk_sys) begin
    if (rst) begin
      taken_reg <= 1'b0;
      flush_reg <= 1'b0;
    end else begin
      taken_reg <= 1'b0;
      flush_reg <= 1'b0;
      if (issue && op_code == `OP_BRANCH &&
          cond_true(cond_code, c_reg, n_reg, v_reg, z_reg,
                    ovfa_reg, ovfb_reg, sata_reg, satb_reg)) begin
        taken_reg <= 1'b1;
        flush_reg <= 1'b1;
      end
    end
  end

  // ========================================================
  // control register write
  always @(posedge clk_sys) begin
    if (rst)
      ctrl_reg <= `CTRL_RESET;
    else if (reg_wr_en && reg_addr == `REG_CTRL)
      ctrl_reg <= reg_wr_data[1:0];
  end

  // ========================================================
  // register read; data stand one cycle, zero otherwise
  always @(posedge clk_sys) begin
    if (rst) begin
      rd_data_reg <= 16'h0000;
    end else if (!reg_rd_en) begin
      rd_data_reg <= 16'h0000;
    end else if (reg_addr == `REG_STATUS) begin
      rd_data_reg <= status_img;
    end else if (reg_addr == `REG_CTRL) begin
      rd_data_reg <= {14'h0000, ctrl_reg};
    end else if (reg_addr == `REG_ACCA_LOW) begin
      rd_data_reg <= acc_a_reg[15:0];
    end else if (reg_addr == `REG_ACCA_HIGH) begin
      rd_data_reg <= acc_a_reg[31:16];
    end else if (reg_addr == `REG_ACCA_UPPER) begin
      rd_data_reg <= {{(48-ACC_W){acc_a_reg[ACC_W-1]}},
                      acc_a_reg[ACC_W-1:32]};
    end else if (reg_addr == `REG_ACCB_LOW) begin
      rd_data_reg <= acc_b_reg[15:0];
    end else if (reg_addr == `REG_ACCB_HIGH) begin
      rd_data_reg <= acc_b_reg[31:16];
    end else begin
      rd_data_reg <= {{(48-ACC_W){acc_b_reg[ACC_W-1]}},
                      acc_b_reg[ACC_W-1:32]};
    end
  end

  // ========================================================
  // outputs straight from flip-flops
  assign reg_rd_data          = rd_data_reg;
  assign result               = result_reg;
  assign result_we            = result_we_reg;
  assign branch_taken         = taken_reg;
  assign flush                = flush_reg;
  assign carry_flag           = c_reg;
  assign digit_carry_flag     = hc_reg;
  assign negative_flag        = n_reg;
  assign overflow_flag        = v_reg;
  assign zero_flag            = z_reg;
  assign acc_a_overflow_flag  = ovfa_reg;
  assign acc_b_overflow_flag  = ovfb_reg;
  assign acc_a_saturated_flag = sata_reg;
  assign acc_b_saturated_flag = satb_reg;

endmodule
`default_nettype wire

//--- alu_shift_branch_subset_consts.vh
// constants for the add, shift and branch datapath slice
`ifndef ALU_SHIFT_BRANCH_SUBSET_CONSTS_VH
`define ALU_SHIFT_BRANCH_SUBSET_CONSTS_VH

// ==========================================================
// operation codes on op_code
`define OP_ADD_ACC      3'h0
`define OP_ADD_CARRY    3'h1
`define OP_SHR_ONE      3'h2
`define OP_SHR_BY_REG   3'h3
`define OP_SHR_BY_LIT   3'h4
`define OP_BRANCH       3'h5

// ==========================================================
// branch condition codes on cond_code
`define COND_C          5'h00
`define COND_GE         5'h01
`define COND_GEU        5'h02
`define COND_GT         5'h03
`define COND_GTU        5'h04
`define COND_LE         5'h05
`define COND_LEU        5'h06
`define COND_LT         5'h07
`define COND_LTU        5'h08
`define COND_N          5'h09
`define COND_NC         5'h0a
`define COND_NN         5'h0b
`define COND_NOV        5'h0c
`define COND_NZ         5'h0d
`define COND_OVFA       5'h0e
`define COND_OVFB       5'h0f
`define COND_OVF        5'h10
`define COND_SATA       5'h11
`define COND_SATB       5'h12
`define COND_ALWAYS     5'h13
`define COND_Z          5'h14

// ==========================================================
// register offsets on reg_addr
`define REG_STATUS      3'h0
`define REG_CTRL        3'h1
`define REG_ACCA_LOW    3'h2
`define REG_ACCA_HIGH   3'h3
`define REG_ACCA_UPPER  3'h4
`define REG_ACCB_LOW    3'h5
`define REG_ACCB_HIGH   3'h6
`define REG_ACCB_UPPER  3'h7

// ==========================================================
// status register bit positions
`define ST_C            0
`define ST_Z            1
`define ST_OVF          2
`define ST_N            3
`define ST_DIGIT        8
`define ST_SATB         12
`define ST_SATA         13
`define ST_OVFB         14
`define ST_OVFA         15

// ==========================================================
// control register bit positions and reset values
`define CTRL_SAT_A      0
`define CTRL_SAT_B      1
`define CTRL_RESET      2'h0
`define STATUS_RESET    9'h000

`endif

//--- alu_slice_properties.sv
// assertion checker for the add, shift and branch slice
`timescale 1ns/100ps
`default_nettype none
`include "alu_shift_branch_subset_consts.vh"
module alu_slice_checker #(
  parameter ACC_W = 40                       // accumulator width
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire logic [2:0]  op_code,
  input wire logic [4:0]  cond_code,
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  input wire logic [4:0]  five_bit_literal,
  input wire logic        reg_wr_en,
  input wire logic [15:0] result,
  input wire logic        result_we,
  input wire logic        branch_taken,
  input wire logic        flush,
  input wire logic        carry_flag,
  input wire logic        digit_carry_flag,
  input wire logic        negative_flag,
  input wire logic        overflow_flag,
  input wire logic        zero_flag,
  input wire logic        acc_a_overflow_flag,
  input wire logic        acc_b_saturated_flag
);
  // ==========================================================
  // helper terms
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire        go = op_valid && !flush;      // op accepted
  wire        br = go && op_code == `OP_BRANCH;
  wire [16:0] sum = {1'b0, operand_a} + {1'b0, operand_b}
                    + {16'h0, carry_flag};
  wire [15:0] lit_sh = $signed(operand_a) >>> five_bit_literal;
  wire [4:0]  fl = {carry_flag, digit_carry_flag, negative_flag,
                    overflow_flag, zero_flag};

  // ==========================================================
  // properties
  flush_pair_a: assert property (flush == branch_taken)
    else $error("flush and taken differ");
  taken_cause_a: assert property (
    branch_taken |-> $past(br)) else $error("taken without branch");
  branch_quiet_a: assert property (
    br && !reg_wr_en |=> $stable(fl) && !result_we)
    else $error("branch touched flags");
  cadd_sum_a: assert property (
    go && op_code == `OP_ADD_CARRY |=> result_we
      && {carry_flag, result} == $past(sum))
    else $error("carry add sum wrong");
  cadd_nz_a: assert property (
    go && op_code == `OP_ADD_CARRY |=> zero_flag == (result == 16'h0)
      && negative_flag == result[15]) else $error("carry add n z wrong");
  shr_one_a: assert property (
    go && op_code == `OP_SHR_ONE |=> !overflow_flag
      && result == {$past(operand_a[15]), $past(operand_a[15:1])}
      && carry_flag == $past(operand_a[0])) else $error("shift one wrong");
  shr_keep_a: assert property (
    go && (op_code == `OP_SHR_BY_REG || op_code == `OP_SHR_BY_LIT)
      && !reg_wr_en |=> $stable({carry_flag, overflow_flag}))
    else $error("amount shift touched carry");
  shr_lit_a: assert property (
    go && op_code == `OP_SHR_BY_LIT |=> result == $past(lit_sh)
      && zero_flag == (result == 16'h0)) else $error("literal shift wrong");
  acc_quiet_a: assert property (
    go && op_code == `OP_ADD_ACC && !reg_wr_en
      |=> $stable(fl) && !result_we)
    else $error("acc add touched word flags");
  le_cond_a: assert property (
    br && cond_code == `COND_LE |=> branch_taken
      == $past(zero_flag || (negative_flag ^ overflow_flag)))
    else $error("le condition wrong");
  ovfa_cond_a: assert property (
    br && cond_code == `COND_OVFA
      |=> branch_taken == $past(acc_a_overflow_flag))
    else $error("acc a overflow condition wrong");
  satb_cond_a: assert property (
    br && cond_code == `COND_SATB
      |=> branch_taken == $past(acc_b_saturated_flag))
    else $error("acc b saturation condition wrong");

  // ==========================================================
  // main scenarios
  cover property (br ##1 branch_taken);
  cover property (go && op_code == `OP_ADD_CARRY && carry_flag);
  cover property ($rose(acc_b_saturated_flag));
endmodule
bind alu_shift_branch_subset alu_slice_checker #(.ACC_W(ACC_W)) chk (
  .clk_sys, .rst, .op_valid, .op_code, .cond_code, .operand_a, .operand_b,
  .five_bit_literal, .reg_wr_en, .result, .result_we, .branch_taken, .flush,
  .carry_flag, .digit_carry_flag, .negative_flag, .overflow_flag, .zero_flag,
  .acc_a_overflow_flag, .acc_b_saturated_flag);
`default_nettype wire

//--- tb_top.sv
// self-checking testbench for the add, shift and branch slice
`timescale 1ns/100ps
`default_nettype none
`include "alu_shift_branch_subset_consts.vh"
module tb_top;
  // ==========================================================
  // stimulus, outputs and model state
  logic        clk_sys = 1'b0;              // 50 ns clock
  logic        rst, op_valid, acc_sel, reg_wr_en, reg_rd_en;
  logic [2:0]  op_code, reg_addr;
  logic [4:0]  cond_code, five_bit_literal;
  logic [3:0]  shift_lit4;
  logic [15:0] operand_a, operand_b, reg_wr_data, res_m, rd;
  wire  [15:0] reg_rd_data, result;
  wire         result_we, branch_taken, flush, carry_flag, digit_carry_flag;
  wire         negative_flag, overflow_flag, zero_flag, acc_a_overflow_flag;
  wire         acc_b_overflow_flag, acc_a_saturated_flag, acc_b_saturated_flag;
  wire  [8:0]  seen = {carry_flag, digit_carry_flag, negative_flag,
                       overflow_flag, zero_flag, acc_a_overflow_flag,
                       acc_b_overflow_flag, acc_a_saturated_flag,
                       acc_b_saturated_flag};
  logic [8:0]  f;                            // model flags, same order
  logic [39:0] acc [2];                      // model accumulators
  logic [1:0]  ctrl;                         // model saturation enables
  logic [31:0] seed, r1, r2;
  int          mismatches, check_count, i;

  alu_shift_branch_subset #(.ACC_W(40)) DUT (.clk_sys, .rst, .op_valid,
    .op_code, .cond_code, .acc_sel, .operand_a, .operand_b, .five_bit_literal,
    .shift_lit4, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data,
    .result, .result_we, .branch_taken, .flush, .carry_flag, .digit_carry_flag,
    .negative_flag, .overflow_flag, .zero_flag, .acc_a_overflow_flag,
    .acc_b_overflow_flag, .acc_a_saturated_flag, .acc_b_saturated_flag);

  always #25 clk_sys = ~clk_sys;             // 20 MHz

  // ==========================================================
  // comparison, register bus and closing
  task check(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task reg_write(input [2:0] a, input [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wr_data <= d; reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    if (a == `REG_STATUS) f = {d[0], d[8], d[3], d[2], d[1], d[15:12]};
    if (a == `REG_CTRL) ctrl = d[1:0];
  endtask
  task reg_read(input [2:0] a);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 rd = reg_rd_data;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // expected branch decision from the flags
  function logic cond_ok(input [4:0] k, input [8:0] q);
    logic c, n, v, z;
    c = q[8]; n = q[6]; v = q[5]; z = q[4];
    case (k)
      `COND_C, `COND_GEU: cond_ok = c;
      `COND_GE:  cond_ok = !(n ^ v);
      `COND_GT:  cond_ok = !z && !(n ^ v);
      `COND_GTU: cond_ok = c && !z;
      `COND_LE:  cond_ok = z || (n ^ v);
      `COND_LEU: cond_ok = !c || z;
      `COND_LT:  cond_ok = n ^ v;
      `COND_LTU, `COND_NC: cond_ok = !c;
      `COND_N:   cond_ok = n;
      `COND_NN:  cond_ok = !n;
      `COND_NOV: cond_ok = !v;
      `COND_NZ:  cond_ok = !z;
      `COND_OVFA: cond_ok = q[3];
      `COND_OVFB: cond_ok = q[2];
      `COND_OVF:  cond_ok = v;
      `COND_SATA: cond_ok = q[1];
      `COND_SATB: cond_ok = q[0];
      `COND_ALWAYS: cond_ok = 1'b1;
      `COND_Z:   cond_ok = z;
      default:   cond_ok = 1'b0;            // unused codes never taken
    endcase
  endfunction

  // ==========================================================
  // one operation: model, drive, compare
  task run_op(input [2:0] oc, input [4:0] cc, input sel, input [15:0] a, b,
              input [4:0] l5, input [3:0] l4);
    logic [16:0] s;
    logic [15:0] r;
    logic [40:0] t;
    logic [39:0] ad;
    logic        we, tk;
    we = 0; tk = 0; r = res_m;
    case (oc)
      `OP_ADD_CARRY: begin
        s = a + b + f[8];
        r = s[15:0]; we = 1;
        f[8:4] = {s[16], (a[3:0] + b[3:0] + f[8]) > 15, r[15],
                  a[15] == b[15] && r[15] != a[15], r == 16'h0};
      end
      `OP_SHR_ONE: begin
        r = $signed(a) >>> 1; we = 1;
        f[8] = a[0]; f[6:4] = {r[15], 1'b0, r == 16'h0};
      end
      `OP_SHR_BY_REG, `OP_SHR_BY_LIT: begin
        r = $signed(a) >>> (oc == `OP_SHR_BY_REG ? b[4:0] : l5); we = 1;
        f[6] = r[15]; f[4] = r == 16'h0;
      end
      `OP_BRANCH: tk = cond_ok(cc, f);
      `OP_ADD_ACC: begin
        ad = {{8{a[15]}}, a, 16'h0};
        if (l4[3]) ad = ad << (5'h10 - {1'b0, l4});
        else ad = $signed(ad) >>> l4;
        t = {acc[sel][39], acc[sel]} + {ad[39], ad};
        if (t[40] != t[39] && ctrl[sel]) begin
          acc[sel] = t[40] ? {1'b1, 39'h0} : {1'b0, {39{1'b1}}};
          f[1 - sel] = 1'b1;
        end else acc[sel] = t[39:0];
        f[3 - sel] = !(&acc[sel][39:31] || ~|acc[sel][39:31]);
      end
      default: ;
    endcase
    @(posedge clk_sys);
    op_valid <= 1'b1; op_code <= oc; cond_code <= cc; acc_sel <= sel;
    operand_a <= a; operand_b <= b; five_bit_literal <= l5; shift_lit4 <= l4;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    check(seen, f);
    check(result_we, we);
    check(result, r);
    check(branch_taken, tk);
    check(flush, tk);
    res_m = r;
    if (oc == `OP_ADD_ACC) for (int k = 0; k < 3; k++) begin
      reg_read(3'(2 + 3 * sel + k));
      check(rd, k == 0 ? acc[sel][15:0] : k == 1 ? acc[sel][31:16] :
            {{8{acc[sel][39]}}, acc[sel][39:32]});
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'hbdb1733a; rst = 1; op_valid = 0; op_code = 0; cond_code = 0;
    acc_sel = 0; operand_a = 0; operand_b = 0; five_bit_literal = 0;
    shift_lit4 = 0; reg_addr = 0; reg_wr_data = 0; reg_wr_en = 0;
    reg_rd_en = 0; f = 0; ctrl = 0; res_m = 0; acc[0] = 0; acc[1] = 0;
    mismatches = 0; check_count = 0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    reg_read(`REG_STATUS); check(rd, 16'h0000);
    reg_read(`REG_CTRL); check(rd, 16'h0000);
    reg_write(`REG_CTRL, 16'hffff); reg_read(`REG_CTRL); check(rd, 16'h0003);
    reg_write(`REG_STATUS, 16'hffff); reg_read(`REG_STATUS);
    check(rd, 16'hf10f);
    reg_write(`REG_ACCA_HIGH, 16'hffff); reg_read(`REG_ACCA_HIGH);
    check(rd, 16'h0000);
    $display("test registers done");
    for (i = 0; i < 32; i++) begin         // every condition code
      r1 = $random(seed);
      reg_write(`REG_STATUS, r1[15:0]);
      reg_read(`REG_STATUS);
      check(rd, r1[15:0] & 16'hf10f);
      run_op(`OP_BRANCH, i[4:0], 1'b0, 16'h0, 16'h0, 5'h0, 4'h0);
    end
    $display("test conditions done");
    reg_write(`REG_STATUS, 16'h0001);      // carry in makes zero
    run_op(`OP_ADD_CARRY, 5'h0, 1'b0, 16'hffff, 16'h0000, 5'h0, 4'h0);
    run_op(`OP_SHR_BY_REG, 5'h0, 1'b0, 16'h8001, 16'h001f, 5'h0, 4'h0);
    run_op(`OP_SHR_BY_LIT, 5'h0, 1'b0, 16'h4000, 16'h0, 5'h1f, 4'h0);
    run_op(`OP_SHR_ONE, 5'h0, 1'b0, 16'h8001, 16'h0, 5'h0, 4'h0);
    repeat (6) run_op(`OP_ADD_ACC, 5'h0, 1'b0, 16'h7fff, 16'h0, 5'h0, 4'h8);
    repeat (6) run_op(`OP_ADD_ACC, 5'h0, 1'b1, 16'h8000, 16'h0, 5'h0, 4'h8);
    @(posedge clk_sys);                    // op in the flush slot is dropped
    op_valid <= 1'b1; op_code <= `OP_BRANCH; cond_code <= `COND_ALWAYS;
    @(posedge clk_sys);
    op_code <= `OP_ADD_CARRY; operand_a <= 16'h0001;
    #1 check(flush, 1'b1);
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1 check(result_we, 1'b0);
    check(seen, f);
    $display("test corners done");
    for (i = 0; i < 400; i++) begin        // random traffic
      r1 = $random(seed);
      r2 = $random(seed);
      if (i % 25 == 0) reg_write(`REG_CTRL, r2[31:16]);
      run_op(3'(r1 % 8), r1[4:0], r1[5], r2[15:0], r2[31:16], r1[10:6],
             r1[14:11]);
    end
    $display("test random done");
    close_out;
  end

  // ==========================================================
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
